// *** rtl/pcrb_bank.sv ***
/*
  Capability register bank of one switch port: the serial memory data word,
  the capability header and the device capability word.
  Assumes the serial memory engine, the control and address bits sharing the
  data word, and the message decoder sit outside and share core_clk. Strap
  pins are asynchronous and must be steady while rst_b is held.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Software data in upper half is sent.
// - Read completion loads data field; resets zero.
// - Capability identifier always reads 10h.
// - Next pointer always reads zero.
// - Capability version reads binary 0010.
// - Port type 0101 upstream, 0110 downstream.
// - Slot present from strap, overridable.
// - Interrupt message number always reads zero.
// - Max payload from strap, overridable.
// - Phantom function field always reads zero.
// - Extended tag bit always reads zero.
// - Both latency fields read zero.
// - Role based error bit resets one.
// - Upstream captures slot power value byte.
// - Upstream captures slot power scale bits.
// - Start bit launches a memory cycle.
// - Command bit selects read or write.
module pcrb_bank
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // Straps and port role
  input  wire logic              slot_present_strap,
  input  wire logic              large_payload_strap,
  input  wire logic              port_is_upstream,
  // Configuration access
  input  wire pcrb_pkg::pcrb_req_t cfg_req,
  output logic [31:0]            cfg_rdata,
  output logic                   cfg_rvalid,
  // Management and autoload overrides
  input  wire pcrb_pkg::pcrb_ovr_t ovr_req,
  // Slot power limit message
  input  wire pcrb_pkg::pcrb_spl_t spl_msg,
  // Serial memory engine
  input  wire logic [15:0]       sm_ctrl_lo,
  input  wire logic              sm_rd_done,
  input  wire logic [15:0]       sm_rd_data,
  output logic                   sm_start,
  output logic                   sm_cmd_write,
  output logic [15:0]            sm_wr_data
);
  import pcrb_pkg::*;

  logic [2:0]  slot_sync_reg;
  logic [2:0]  pl_sync_reg;
  logic        slot_stable_reg;
  logic        pl_stable_reg;
  logic [15:0] sm_data_reg;
  logic        slot_present_reg;
  logic [2:0]  mps_reg;
  logic        rber_reg;
  logic [7:0]  splv_reg;
  logic [1:0]  spls_reg;
  logic [31:0] cfg_rdata_reg;
  logic        cfg_rvalid_reg;
  logic        sm_start_reg;
  logic        sm_cmd_reg;

  wire         sel_sm   = cfg_req.addr == PCRB_OFF_SMEM_DATA;
  wire         sel_hdr  = cfg_req.addr == PCRB_OFF_CAP_HDR;
  wire         sel_dc   = cfg_req.addr == PCRB_OFF_DEV_CAP;
  wire         ovr_hdr  = ovr_req.wr && ovr_req.addr == PCRB_OFF_CAP_HDR;
  wire         ovr_dc   = ovr_req.wr && ovr_req.addr == PCRB_OFF_DEV_CAP;
  wire         sw_sm_wr = cfg_req.wr && sel_sm;
  wire [15:0]  sw_data  = cfg_req.wdata[PCRB_SM_DATA_LSB +: 16];
  wire         slot_chg = slot_sync_reg[1] == slot_sync_reg[2];
  wire         pl_chg   = pl_sync_reg[1] == pl_sync_reg[2];
  wire [3:0]   port_type = port_is_upstream ? PCRB_TYPE_UP : PCRB_TYPE_DOWN;
  wire [2:0]   mps_strap = pl_stable_reg ? PCRB_MPS_512 : PCRB_MPS_256;

  // Byte-lane merge of the software write into the data field.
  wire [15:0]  sm_data_sw = {cfg_req.be[3] ? sw_data[15:8] : sm_data_reg[15:8],
                             cfg_req.be[2] ? sw_data[7:0]  : sm_data_reg[7:0]};

  // Read images; unassigned positions are reserved and read zero.
  logic [31:0] hdr_img;
  logic [31:0] dc_img;
  logic [31:0] sm_img;
  always_comb
  begin
    hdr_img = 32'h0000_0000;
    hdr_img[PCRB_HDR_ID_LSB +: 8]   = PCRB_CAP_ID;
    hdr_img[PCRB_HDR_NEXT_LSB +: 8] = PCRB_NEXT_PTR;
    hdr_img[PCRB_HDR_VER_LSB +: 4]  = PCRB_CAP_VER;
    hdr_img[PCRB_HDR_TYPE_LSB +: 4] = port_type;
    hdr_img[PCRB_HDR_SLOT_BIT]      = slot_present_reg;
    hdr_img[PCRB_HDR_MSGN_LSB +: 5] = PCRB_MSG_NUM;
  end

  always_comb
  begin
    dc_img = 32'h0000_0000;
    dc_img[PCRB_DC_MPS_LSB +: 3]  = mps_reg;
    dc_img[PCRB_DC_PHAN_LSB +: 2] = PCRB_PHANTOM;
    dc_img[PCRB_DC_ETAG_BIT]      = PCRB_EXT_TAG;
    dc_img[PCRB_DC_L0S_LSB +: 3]  = PCRB_L0S_LAT;
    dc_img[PCRB_DC_L1_LSB +: 3]   = PCRB_L1_LAT;
    dc_img[PCRB_DC_RBER_BIT]      = rber_reg;
    dc_img[PCRB_DC_SPLV_LSB +: 8] = splv_reg;
    dc_img[PCRB_DC_SPLS_LSB +: 2] = spls_reg;
  end

  always_comb
  begin
    sm_img = 32'h0000_0000;
    sm_img[15:0] = sm_ctrl_lo;
    sm_img[PCRB_SM_DATA_LSB +: 16] = sm_data_reg;
  end

  wire [31:0] rd_mux = sel_sm  ? sm_img  :
                       sel_hdr ? hdr_img :
                       sel_dc  ? dc_img  : 32'h0000_0000;

  // Strap synchronisers run free so the settled level is ready at release.
  always_ff @(posedge core_clk)
  begin
    slot_sync_reg <= {slot_sync_reg[1:0], slot_present_strap};
    pl_sync_reg   <= {pl_sync_reg[1:0], large_payload_strap};
  end

  always_ff @(posedge core_clk)
  begin
    if (slot_chg)
      slot_stable_reg <= slot_sync_reg[2];
    if (pl_chg)
      pl_stable_reg <= pl_sync_reg[2];
  end

  // Data field of the shared serial memory word.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      sm_data_reg <= PCRB_SM_DATA_RST;
    else if (sm_rd_done)
      sm_data_reg <= sm_rd_data;
    else if (sw_sm_wr)
      sm_data_reg <= sm_data_sw;
  end

  // Launch strobe and direction toward the serial memory engine.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sm_start_reg <= 1'b0;
      sm_cmd_reg   <= 1'b0;
    end
    else
    begin
      sm_start_reg <= sw_sm_wr && cfg_req.be[0] && cfg_req.wdata[PCRB_SM_START_BIT];
      if (sw_sm_wr && cfg_req.be[0])
        sm_cmd_reg <= cfg_req.wdata[PCRB_SM_CMD_BIT];
    end
  end

  // Strap defaults are taken while reset is held; overrides may follow.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      slot_present_reg <= slot_stable_reg;
      mps_reg          <= mps_strap;
      rber_reg         <= PCRB_RBER_RST;
    end
    else
    begin
      if (ovr_hdr && ovr_req.be[3])
        slot_present_reg <= ovr_req.wdata[PCRB_HDR_SLOT_BIT];
      if (ovr_dc && ovr_req.be[0])
        mps_reg <= ovr_req.wdata[PCRB_DC_MPS_LSB +: 3];
      if (ovr_dc && ovr_req.be[1])
        rber_reg <= ovr_req.wdata[PCRB_DC_RBER_BIT];
    end
  end

  // Slot power limit captured only where the port faces upstream.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      splv_reg <= PCRB_SPLV_RST;
      spls_reg <= PCRB_SPLS_RST;
    end
    else if (spl_msg.valid && port_is_upstream)
    begin
      splv_reg <= spl_msg.value;
      spls_reg <= spl_msg.scale;
    end
  end

  // Registered read answer one cycle after the request.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cfg_rdata_reg  <= 32'h0000_0000;
      cfg_rvalid_reg <= 1'b0;
    end
    else
    begin
      cfg_rvalid_reg <= cfg_req.rd;
      if (cfg_req.rd)
        cfg_rdata_reg <= rd_mux;
    end
  end

  assign cfg_rdata    = cfg_rdata_reg;
  assign cfg_rvalid   = cfg_rvalid_reg;
  assign sm_start     = sm_start_reg;
  assign sm_cmd_write = sm_cmd_reg;
  assign sm_wr_data   = sm_data_reg;

endmodule

`default_nettype wire

// *** rtl/pcrb_pkg.sv ***
/*
  Package of the capability register bank: register offsets, field positions,
  fixed field values, reset values and the packed carriers shared by the ports.
  Assumes a single core clock domain and byte offsets in configuration space.
*/
package pcrb_pkg;

  // Configuration space byte offsets.
  localparam logic [11:0] PCRB_OFF_SMEM_DATA = 12'h0bc;
  localparam logic [11:0] PCRB_OFF_CAP_HDR   = 12'h0c0;
  localparam logic [11:0] PCRB_OFF_DEV_CAP   = 12'h0c4;

  // Serial memory shared word.
  localparam int PCRB_SM_START_BIT = 0;
  localparam int PCRB_SM_CMD_BIT   = 1;
  localparam int PCRB_SM_DATA_LSB  = 16;
  localparam logic [15:0] PCRB_SM_DATA_RST = 16'h0000;

  // Capability header fields.
  localparam int PCRB_HDR_ID_LSB    = 0;
  localparam int PCRB_HDR_NEXT_LSB  = 8;
  localparam int PCRB_HDR_VER_LSB   = 16;
  localparam int PCRB_HDR_TYPE_LSB  = 20;
  localparam int PCRB_HDR_SLOT_BIT  = 24;
  localparam int PCRB_HDR_MSGN_LSB  = 25;
  localparam logic [7:0] PCRB_CAP_ID      = 8'h10;
  localparam logic [7:0] PCRB_NEXT_PTR    = 8'h00;
  localparam logic [3:0] PCRB_CAP_VER     = 4'h2;
  localparam logic [3:0] PCRB_TYPE_UP     = 4'h5;
  localparam logic [3:0] PCRB_TYPE_DOWN   = 4'h6;
  localparam logic [4:0] PCRB_MSG_NUM     = 5'h00;

  // Device capability fields.
  localparam int PCRB_DC_MPS_LSB   = 0;
  localparam int PCRB_DC_PHAN_LSB  = 3;
  localparam int PCRB_DC_ETAG_BIT  = 5;
  localparam int PCRB_DC_L0S_LSB   = 6;
  localparam int PCRB_DC_L1_LSB    = 9;
  localparam int PCRB_DC_RBER_BIT  = 15;
  localparam int PCRB_DC_SPLV_LSB  = 18;
  localparam int PCRB_DC_SPLS_LSB  = 26;
  localparam logic [2:0] PCRB_MPS_256     = 3'h1;
  localparam logic [2:0] PCRB_MPS_512     = 3'h2;
  localparam logic [1:0] PCRB_PHANTOM     = 2'h0;
  localparam logic       PCRB_EXT_TAG     = 1'b0;
  localparam logic [2:0] PCRB_L0S_LAT     = 3'h0;
  localparam logic [2:0] PCRB_L1_LAT      = 3'h0;
  localparam logic       PCRB_RBER_RST    = 1'b1;
  localparam logic [7:0] PCRB_SPLV_RST    = 8'h00;
  localparam logic [1:0] PCRB_SPLS_RST    = 2'h0;

  // Configuration access request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcrb_req_t;

  // Override write from the management port or autoload.
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcrb_ovr_t;

  // Captured slot power limit message.
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } pcrb_spl_t;

endpackage

// *** dv/pcrb_bank_props.sv ***
/*
  Checker of the capability register bank, bound to pcrb_bank.
  Assumes one core_clk domain and a synchronous active low rst_b.
*/
`timescale 1ns/1ps
`default_nettype none
module pcrb_bank_props
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rst_b,
  // Straps and port role
  input wire logic                slot_present_strap,
  input wire logic                large_payload_strap,
  input wire logic                port_is_upstream,
  // Configuration access
  input wire pcrb_pkg::pcrb_req_t cfg_req,
  input wire logic [31:0]         cfg_rdata,
  input wire logic                cfg_rvalid,
  // Overrides and messages
  input wire pcrb_pkg::pcrb_ovr_t ovr_req,
  input wire pcrb_pkg::pcrb_spl_t spl_msg,
  // Serial memory engine
  input wire logic [15:0]         sm_ctrl_lo,
  input wire logic                sm_rd_done,
  input wire logic [15:0]         sm_rd_data,
  input wire logic                sm_start,
  input wire logic                sm_cmd_write,
  input wire logic [15:0]         sm_wr_data
);
  import pcrb_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic rd_hdr = cfg_req.rd && cfg_req.addr == PCRB_OFF_CAP_HDR;
  wire logic rd_dc  = cfg_req.rd && cfg_req.addr == PCRB_OFF_DEV_CAP;
  wire logic wr_sm  = cfg_req.wr && cfg_req.addr == PCRB_OFF_SMEM_DATA;

  id_next_a: assert property (rd_hdr |=> cfg_rvalid && cfg_rdata[15:0] == 16'h0010)
    else $error("header id or pointer wrong");
  ver_msg_a: assert property (rd_hdr |=> cfg_rdata[19:16] == 4'h2 && cfg_rdata[31:25] == 7'h0)
    else $error("header version or message number wrong");
  port_type_a: assert property (rd_hdr |=> cfg_rdata[23:20] == ($past(port_is_upstream) ? 4'h5 : 4'h6))
    else $error("port type wrong");
  dc_fixed_a: assert property (rd_dc |=> cfg_rvalid && cfg_rdata[14:3] == 12'h0 &&
    cfg_rdata[17:16] == 2'h0 && cfg_rdata[31:28] == 4'h0)
    else $error("device capability fixed fields wrong");
  spl_cap_a: assert property (spl_msg.valid && port_is_upstream ##2 rd_dc |=>
    cfg_rdata[27:18] == {$past(spl_msg.scale, 3), $past(spl_msg.value, 3)})
    else $error("slot power not captured");
  start_cmd_a: assert property (wr_sm && cfg_req.be[0] |=> sm_start == $past(cfg_req.wdata[0]) &&
    sm_cmd_write == $past(cfg_req.wdata[1]))
    else $error("start or command wrong");
  data_hi_a: assert property (wr_sm && cfg_req.be[3] && !sm_rd_done |=>
    sm_wr_data[15:8] == $past(cfg_req.wdata[31:24]))
    else $error("data field high byte not written");
  rd_load_a: assert property (sm_rd_done |=> sm_wr_data == $past(sm_rd_data))
    else $error("read data not loaded");
endmodule
bind pcrb_bank pcrb_bank_props u_props (.core_clk(core_clk), .rst_b(rst_b),
  .slot_present_strap(slot_present_strap), .large_payload_strap(large_payload_strap),
  .port_is_upstream(port_is_upstream), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .ovr_req(ovr_req), .spl_msg(spl_msg), .sm_ctrl_lo(sm_ctrl_lo),
  .sm_rd_done(sm_rd_done), .sm_rd_data(sm_rd_data), .sm_start(sm_start),
  .sm_cmd_write(sm_cmd_write), .sm_wr_data(sm_wr_data));
`default_nettype wire

// *** dv/pcrb_bank_tb.sv ***
/*
  Self-checking bench of the capability register bank.
  Assumes the checker is bound in from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module pcrb_bank_tb;
  import pcrb_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic strap = 1'b0;
  pcrb_req_t req = '0;
  pcrb_ovr_t ovr = '0;
  pcrb_spl_t spl = '0;
  logic sm_done = 1'b0;
  logic [15:0] sm_rdat = 16'h0;
  logic [31:0] rdata;
  logic rvalid;
  logic sm_start;
  logic sm_cmd;
  logic [15:0] sm_wdat;
  logic [31:0] sp;
  logic [31:0] hdr;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;

  // One strap level drives both straps and the port role, so each pass covers a pairing.
  pcrb_bank u_dut (.core_clk(core_clk), .rst_b(rst_b), .slot_present_strap(strap),
    .large_payload_strap(strap), .port_is_upstream(strap), .cfg_req(req),
    .cfg_rdata(rdata), .cfg_rvalid(rvalid), .ovr_req(ovr), .spl_msg(spl),
    .sm_ctrl_lo(16'h5a5a), .sm_rd_done(sm_done), .sm_rd_data(sm_rdat),
    .sm_start(sm_start), .sm_cmd_write(sm_cmd), .sm_wr_data(sm_wdat));

  initial forever #2 core_clk = ~core_clk;

  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 chk($sformatf("read %h", a), e, rdata);
  endtask

  task automatic wr(input logic o, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge core_clk);
    if (o)
      ovr <= '{1'b1, a, b, d};
    else
      req <= '{1'b0, 1'b1, a, b, d};
    @(posedge core_clk);
    ovr.wr <= 1'b0;
    req.wr <= 1'b0;
    #1;
  endtask

  // Slot power message and memory read completion land in the same cycle.
  task automatic hw;
    @(posedge core_clk);
    spl <= '{1'b1, 8'hab, 2'h2};
    sm_done <= 1'b1;
    sm_rdat <= 16'h5678;
    @(posedge core_clk);
    spl.valid <= 1'b0;
    sm_done <= 1'b0;
    #1;
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    for (int s = 0; s < 2; s++)
    begin
      @(posedge core_clk);
      // Straps settle through their synchronisers before reset samples them.
      strap <= s[0];
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      sp = s ? 32'h0aac_0000 : 32'h0;
      hdr = {8'h0, s ? 4'h5 : 4'h6, 20'h20010};
      rd(PCRB_OFF_CAP_HDR, hdr | {7'h0, s[0], 24'h0});
      rd(PCRB_OFF_DEV_CAP, s ? 32'h8002 : 32'h8001);
      rd(PCRB_OFF_SMEM_DATA, 32'h0000_5a5a);
      hw();
      rd(PCRB_OFF_DEV_CAP, sp | (s ? 32'h8002 : 32'h8001));
      rd(PCRB_OFF_SMEM_DATA, 32'h5678_5a5a);
      wr(1'b1, PCRB_OFF_DEV_CAP, 4'hf, 32'hffff_7ffc);
      wr(1'b0, PCRB_OFF_DEV_CAP, 4'hf, 32'hffff_ffff);
      rd(PCRB_OFF_DEV_CAP, sp | 32'h4);
      wr(1'b1, PCRB_OFF_CAP_HDR, 4'h8, 32'hff00_0000);
      rd(PCRB_OFF_CAP_HDR, hdr | 32'h0100_0000);
      wr(1'b0, 12'h100, 4'hf, 32'hffff_ffff);
      rd(12'h100, 32'h0);
      wr(1'b0, PCRB_OFF_SMEM_DATA, 4'hf, 32'h1234_0003);
      chk("memory port", 32'h1234_0003, {sm_wdat, 14'h0, sm_cmd, sm_start});
      wr(1'b0, PCRB_OFF_SMEM_DATA, 4'h1, 32'h0000_0001);
      chk("memory port", 32'h1234_0001, {sm_wdat, 14'h0, sm_cmd, sm_start});
      wr(1'b0, PCRB_OFF_SMEM_DATA, 4'h8, 32'hab00_0001);
      chk("memory port", 32'hab34_0000, {sm_wdat, 14'h0, sm_cmd, sm_start});
      rd(PCRB_OFF_SMEM_DATA, 32'hab34_5a5a);
    end
    end_sim();
  end
endmodule
`default_nettype wire
